// ### cdh_defs.vh
// constants for the character display host port
`ifndef CDH_DEFS_VH
`define CDH_DEFS_VH

// timing
`define CDH_CLK_PERIOD_NS 100
`define CDH_BUSY_NS 2000
`define CDH_BUSY_CYCLES ((`CDH_BUSY_NS + `CDH_CLK_PERIOD_NS - 1) / `CDH_CLK_PERIOD_NS)

// strap encodings
`define CDH_STRAP_PARALLEL 1'b1
`define CDH_STRAP_STYLE_68 1'b1

// text ram address ranges
`define CDH_TEXT_FIRST 7'h00
`define CDH_TEXT_1L_LAST 7'h4f
`define CDH_TEXT_L1_LAST 7'h27
`define CDH_TEXT_L2_FIRST 7'h40
`define CDH_TEXT_L2_LAST 7'h67

// serial frame: select bit, direction bit, eight data bits
`define CDH_SER_RS_BIT 4'd0
`define CDH_SER_RW_BIT 4'd1
`define CDH_SER_LAST_BIT 4'd9
`define CDH_SER_DONE 4'd10

// register offsets (byte addresses)
`define CDH_REG_CTRL 4'h0
`define CDH_REG_STATUS 4'h4

// control register fields and reset value
`define CDH_CTRL_PORT_EN 0
`define CDH_CTRL_RESET 1'b1

// status register fields
`define CDH_ST_PTR_LSB 0
`define CDH_ST_BUSY 8
`define CDH_ST_DL 9
`define CDH_ST_TWO_LINE 10
`define CDH_ST_DIR 11
`define CDH_ST_SHIFT 12
`define CDH_ST_GLYPH 13
`define CDH_ST_PS 14
`define CDH_ST_STYLE 15
`define CDH_ST_OFS_LSB 16

// reset values of mode state
`define CDH_DL_RESET 1'b1
`define CDH_TWO_LINE_RESET 1'b0
`define CDH_DIR_RESET 1'b1
`define CDH_SHIFT_RESET 1'b0

// axi responses
`define CDH_RESP_OKAY 2'b00
`define CDH_RESP_DECERR 2'b11

`endif

// ### cdh_sync.v
// two flip-flop synchroniser for pin inputs
`default_nettype none

module cdh_sync #(
   parameter W = 14
) (
   // clock
   input wire clk,
   // pins in, synchronised out
   input wire [W-1:0] d_in,
   output wire [W-1:0] d_out
);

   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   // no reset: the edge detectors downstream load from these during reset
   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         always @(posedge clk) begin
            meta_q[i] <= d_in[i];
            sync_q[i] <= meta_q[i];
         end
      end
   endgenerate

   assign d_out = sync_q;

endmodule // cdh_sync

`default_nettype wire

// ### cdh_ram.v
// single write port memory with asynchronous read
`default_nettype none

module cdh_ram #(
   parameter AW = 7,
   parameter DW = 8
) (
   // clock
   input wire clk,
   // write port
   input wire we,
   input wire [AW-1:0] waddr,
   input wire [DW-1:0] wdata,
   // read port
   input wire [AW-1:0] raddr,
   output wire [DW-1:0] rdata
);

   reg [DW-1:0] mem [0:(1<<AW)-1];

   always @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   assign rdata = mem[raddr];

endmodule // cdh_ram

`default_nettype wire

// ### cdh_port.v
// host command and data port of the character display controller
// Notes on behaviour
// - status read returns busy on line 7, address pointer on lines 6..0.
// - while busy, new instructions are refused; when idle they are executed.
// - one address pointer serves glyph and text ram, set by the last instruction.
// - data write stores the byte in the ram last targeted by an address set.
// - after a data write the pointer steps by one, up or down per entry mode.
// - after a data write the entry mode shift setting shifts the display.
// - data read returns the byte of the targeted ram at the pointer.
// - parallel 8-bit in two bus styles or serial, chosen by two straps.
// - parallel transfers are ignored while serial is strapped.
// - 8-bit mode moves each byte on all eight lines in one transfer.
// - split bytes move high nibble first, then low nibble.
// - 4-bit mode is selected by instruction, not by strap.
// - in 4-bit mode only lines 7..4 are used; lines 3..0 ignored.
// - in 4-bit mode a transfer completes only after both nibbles.
// - in 4-bit mode a busy read also takes two nibbles.
// - data length bit 1 selects 8-bit, 0 selects 4-bit transfers.
// - each data access steps the text address up if direction is 1, else down.
// - single line text addresses run 00h to 4fh.
// - two line text addresses run 00h-27h and 40h-67h.
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`include "cdh_defs.vh"
`default_nettype none

module cdh_port (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // axi4-lite write address
   input wire [3:0] awaddr,
   input wire awvalid,
   output wire awready,
   // axi4-lite write data
   input wire [31:0] wdata,
   input wire [3:0] wstrb,
   input wire wvalid,
   output wire wready,
   // axi4-lite write response
   output reg [1:0] bresp,
   output reg bvalid,
   input wire bready,
   // axi4-lite read address
   input wire [3:0] araddr,
   input wire arvalid,
   output wire arready,
   // axi4-lite read data
   output reg [31:0] rdata,
   output reg [1:0] rresp,
   output reg rvalid,
   input wire rready,
   // host port pins
   input wire register_select,
   input wire enable_or_read_strobe,
   input wire rw_or_write_strobe,
   input wire chip_select_low,
   input wire [7:0] data_line_in,
   output reg [7:0] data_line_out,
   output reg [7:0] data_line_oe,
   // straps
   input wire parallel_serial_strap,
   input wire bus_style_strap
);

   localparam integer BUSY_N = `CDH_BUSY_CYCLES;
   localparam [7:0] BUSY_LOAD = BUSY_N[7:0];

   // synchronised pins
   wire [13:0] pin_s;
   wire ps_s;
   wire style_s;
   wire csb_s;
   wire rs_s;
   wire e_s;
   wire rw_s;
   wire [7:0] db_s;

   cdh_sync #(.W(14)) u_sync (
      .clk(aclk),
      .d_in({parallel_serial_strap, bus_style_strap, chip_select_low, register_select,
             enable_or_read_strobe, rw_or_write_strobe, data_line_in}),
      .d_out(pin_s)
   );

   assign ps_s = pin_s[13];
   assign style_s = pin_s[12];
   assign csb_s = pin_s[11];
   assign rs_s = pin_s[10];
   assign e_s = pin_s[9];
   assign rw_s = pin_s[8];
   assign db_s = pin_s[7:0];

   // state
   reg ctrl_en_q;
   reg [6:0] ptr_q;
   reg glyph_q;
   reg dl_q;
   reg two_line_q;
   reg dir_q;
   reg shift_q;
   reg [6:0] ofs_q;
   reg [7:0] busy_cnt_q;
   reg nib_phase_q;
   reg [3:0] nib_hi_q;
   reg e_prev_q;
   reg rw_prev_q;
   reg sclk_prev_q;
   reg [3:0] ser_cnt_q;
   reg ser_rs_q;
   reg ser_rw_q;
   reg [6:0] ser_sh_q;
   reg [7:0] sdo_sh_q;

   wire busy = (busy_cnt_q != 8'h00);

   // pointer step with the text ram wrap points
   function [6:0] step_addr;
      input [6:0] a;
      input inc;
      input glyph;
      input two;
      begin
         if (glyph) begin
            step_addr = inc ? {1'b0, a[5:0] + 6'h01} : {1'b0, a[5:0] - 6'h01};
         end else if (!two) begin
            if (inc) begin
               step_addr = (a >= `CDH_TEXT_1L_LAST) ? `CDH_TEXT_FIRST : a + 7'h01;
            end else begin
               step_addr = (a == `CDH_TEXT_FIRST) ? `CDH_TEXT_1L_LAST : a - 7'h01;
            end
         end else if (inc) begin
            if (a == `CDH_TEXT_L1_LAST) begin
               step_addr = `CDH_TEXT_L2_FIRST;
            end else if (a >= `CDH_TEXT_L2_LAST) begin
               step_addr = `CDH_TEXT_FIRST;
            end else begin
               step_addr = a + 7'h01;
            end
         end else begin
            if (a == `CDH_TEXT_FIRST) begin
               step_addr = `CDH_TEXT_L2_LAST;
            end else if (a == `CDH_TEXT_L2_FIRST) begin
               step_addr = `CDH_TEXT_L1_LAST;
            end else begin
               step_addr = a - 7'h01;
            end
         end
      end
   endfunction

   // memories
   wire [7:0] text_rd;
   wire [7:0] glyph_rd;
   wire ram_we;
   wire [7:0] xfer_byte;

   cdh_ram #(.AW(7), .DW(8)) u_text (
      .clk(aclk),
      .we(ram_we & ~glyph_q),
      .waddr(ptr_q),
      .wdata(xfer_byte),
      .raddr(ptr_q),
      .rdata(text_rd)
   );

   cdh_ram #(.AW(6), .DW(8)) u_glyph (
      .clk(aclk),
      .we(ram_we & glyph_q),
      .waddr(ptr_q[5:0]),
      .wdata(xfer_byte),
      .raddr(ptr_q[5:0]),
      .rdata(glyph_rd)
   );

   wire [7:0] ram_byte = glyph_q ? glyph_rd : text_rd;
   wire [7:0] stat_byte = {busy, ptr_q};

   // parallel side: 6800 style uses enable plus direction, 8080 style two low strobes
   wire par_mode = ctrl_en_q & (ps_s == `CDH_STRAP_PARALLEL) & ~csb_s;
   wire style68 = (style_s == `CDH_STRAP_STYLE_68);
   wire read_write_select = style68 ? rw_s : ~e_s;
   wire e_fall = e_prev_q & ~e_s;
   wire rdb_rise = ~e_prev_q & e_s;
   wire wrb_rise = ~rw_prev_q & rw_s;
   wire par_wr = par_mode & (style68 ? (e_fall & ~rw_s) : wrb_rise);
   wire par_rd = par_mode & (style68 ? (e_fall & rw_s) : rdb_rise);
   wire par_rd_act = par_mode & (style68 ? (e_s & rw_s) : ~e_s);
   wire par_last = dl_q | nib_phase_q;
   wire [7:0] par_byte = dl_q ? db_s : {nib_hi_q, db_s[7:4]};

   // serial side
   wire ser_mode = ctrl_en_q & (ps_s != `CDH_STRAP_PARALLEL);
   wire ser_sel = ser_mode & ~csb_s;
   wire sclk_s = db_s[5];
   wire sdi_s = db_s[7];
   wire sclk_rise = ser_sel & ~sclk_prev_q & sclk_s;
   wire ser_done = sclk_rise & (ser_cnt_q == `CDH_SER_LAST_BIT);

   // one completed transfer from either side
   wire xfer_go = ((par_wr | par_rd) & par_last) | ser_done;
   wire xfer_rs = ser_done ? ser_rs_q : rs_s;
   wire xfer_rd = ser_done ? ser_rw_q : par_rd;
   assign xfer_byte = ser_done ? {ser_sh_q, sdi_s} : par_byte;

   wire exec_wr = xfer_go & ~xfer_rd & ~busy;
   assign ram_we = exec_wr & xfer_rs;

   // nibble pairing and pin edge history
   always @(posedge aclk) begin
      e_prev_q <= e_s;
      rw_prev_q <= rw_s;
      sclk_prev_q <= sclk_s;
      if (!aresetn) begin
         nib_phase_q <= 1'b0;
         nib_hi_q <= 4'h0;
      end else if (dl_q || !par_mode) begin
         nib_phase_q <= 1'b0;
      end else if (par_wr || par_rd) begin
         nib_phase_q <= ~nib_phase_q;
         if (!nib_phase_q) begin
            nib_hi_q <= db_s[7:4];
         end
      end
   end

   // serial frame: select bit, direction bit, then data msb first
   always @(posedge aclk) begin
      if (!aresetn || !ser_sel) begin
         ser_cnt_q <= 4'h0;
         ser_rs_q <= 1'b0;
         ser_rw_q <= 1'b0;
         ser_sh_q <= 7'h00;
         sdo_sh_q <= 8'h00;
      end else if (sclk_rise && ser_cnt_q != `CDH_SER_DONE) begin
         ser_cnt_q <= ser_cnt_q + 4'h1;
         if (ser_cnt_q == `CDH_SER_RS_BIT) begin
            ser_rs_q <= sdi_s;
         end else if (ser_cnt_q == `CDH_SER_RW_BIT) begin
            ser_rw_q <= sdi_s;
            sdo_sh_q <= ser_rs_q ? ram_byte : stat_byte;
         end else begin
            ser_sh_q <= {ser_sh_q[5:0], sdi_s};
            sdo_sh_q <= {sdo_sh_q[6:0], 1'b0};
         end
      end
   end

   // instruction execution, pointer and busy timer
   always @(posedge aclk) begin
      if (!aresetn) begin
         ptr_q <= 7'h00;
         glyph_q <= 1'b0;
         dl_q <= `CDH_DL_RESET;
         two_line_q <= `CDH_TWO_LINE_RESET;
         dir_q <= `CDH_DIR_RESET;
         shift_q <= `CDH_SHIFT_RESET;
         ofs_q <= 7'h00;
         busy_cnt_q <= 8'h00;
      end else if (exec_wr) begin
         busy_cnt_q <= BUSY_LOAD;
         if (xfer_rs) begin
            ptr_q <= step_addr(ptr_q, dir_q, glyph_q, two_line_q);
            if (shift_q) begin
               ofs_q <= dir_q ? ofs_q + 7'h01 : ofs_q - 7'h01;
            end
         end else begin
            casez (xfer_byte)
               8'b1???????: begin
                  ptr_q <= xfer_byte[6:0];
                  glyph_q <= 1'b0;
               end
               8'b01??????: begin
                  ptr_q <= {1'b0, xfer_byte[5:0]};
                  glyph_q <= 1'b1;
               end
               8'b001?????: begin
                  dl_q <= xfer_byte[4];
                  two_line_q <= xfer_byte[3];
               end
               8'b0001????: begin
                  if (!xfer_byte[3]) begin
                     ptr_q <= step_addr(ptr_q, xfer_byte[2], glyph_q, two_line_q);
                  end else begin
                     ofs_q <= xfer_byte[2] ? ofs_q - 7'h01 : ofs_q + 7'h01;
                  end
               end
               8'b000001??: begin
                  dir_q <= xfer_byte[1];
                  shift_q <= xfer_byte[0];
               end
               8'b0000001?: begin
                  ptr_q <= 7'h00;
                  glyph_q <= 1'b0;
                  ofs_q <= 7'h00;
               end
               8'b00000001: begin
                  ptr_q <= 7'h00;
                  glyph_q <= 1'b0;
                  ofs_q <= 7'h00;
                  dir_q <= 1'b1;
               end
               default: begin
                  ptr_q <= ptr_q;
               end
            endcase
         end
      end else begin
         if (busy) begin
            busy_cnt_q <= busy_cnt_q - 8'h01;
         end
         // a data read also steps the pointer once both nibbles are out
         if (xfer_go && xfer_rd && xfer_rs) begin
            ptr_q <= step_addr(ptr_q, dir_q, glyph_q, two_line_q);
         end
      end
   end

   // pin drive, registered; lines 3..0 stay released in 4-bit mode
   wire [7:0] par_out = par_rs_byte(rs_s, ram_byte, stat_byte);

   function [7:0] par_rs_byte;
      input rs;
      input [7:0] rb;
      input [7:0] sb;
      begin
         par_rs_byte = rs ? rb : sb;
      end
   endfunction

   always @(posedge aclk) begin
      if (!aresetn) begin
         data_line_out <= 8'h00;
         data_line_oe <= 8'h00;
      end else if (par_rd_act && read_write_select) begin
         if (dl_q) begin
            data_line_out <= par_out;
            data_line_oe <= 8'hff;
         end else begin
            data_line_out <= {nib_phase_q ? par_out[3:0] : par_out[7:4], 4'h0};
            data_line_oe <= 8'hf0;
         end
      end else if (ser_sel && ser_rw_q && ser_cnt_q >= 4'd2) begin
         data_line_out <= {1'b0, sdo_sh_q[7], 6'h00};
         data_line_oe <= 8'h40;
      end else begin
         data_line_out <= 8'h00;
         data_line_oe <= 8'h00;
      end
   end

   // axi4-lite write channel
   reg aw_have_q;
   reg w_have_q;
   reg [3:0] aw_addr_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;

   assign awready = ~aw_have_q & ~bvalid;
   assign wready = ~w_have_q & ~bvalid;

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_addr_q <= 4'h0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         bvalid <= 1'b0;
         bresp <= `CDH_RESP_OKAY;
         ctrl_en_q <= `CDH_CTRL_RESET;
      end else begin
         if (awvalid && awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= awaddr;
         end
         if (wvalid && wready) begin
            w_have_q <= 1'b1;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
         end
         if (aw_have_q && w_have_q && !bvalid) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid <= 1'b1;
            if (aw_addr_q == `CDH_REG_CTRL) begin
               bresp <= `CDH_RESP_OKAY;
               if (w_strb_q[0]) begin
                  ctrl_en_q <= w_data_q[`CDH_CTRL_PORT_EN];
               end
            end else if (aw_addr_q == `CDH_REG_STATUS) begin
               bresp <= `CDH_RESP_OKAY;
            end else begin
               bresp <= `CDH_RESP_DECERR;
            end
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // axi4-lite read channel
   wire [31:0] status_word = {8'h00, 1'b0, ofs_q, style_s, ps_s, glyph_q, shift_q, dir_q,
                              two_line_q, dl_q, busy, 1'b0, ptr_q};

   assign arready = ~rvalid;

   always @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= `CDH_RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         if (araddr == `CDH_REG_CTRL) begin
            rdata <= {31'h0000_0000, ctrl_en_q};
            rresp <= `CDH_RESP_OKAY;
         end else if (araddr == `CDH_REG_STATUS) begin
            rdata <= status_word;
            rresp <= `CDH_RESP_OKAY;
         end else begin
            rdata <= 32'h0000_0000;
            rresp <= `CDH_RESP_DECERR;
         end
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end
   end

endmodule // cdh_port

`default_nettype wire

// ### cdh_port_sva.sv
// assertion checker for the host port bus handshakes and pin drivers
`default_nettype none
module cdh_port_sva (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite
   input wire logic [3:0] awaddr,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [3:0] araddr,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   input wire logic rready,
   // pins
   input wire logic chip_select_low,
   input wire logic [7:0] data_line_oe,
   input wire logic parallel_serial_strap
);
   logic [3:0] desel_q;
   logic [3:0] ser_q;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // saturating run lengths; pins pass two sync flops before they act
   always @(posedge aclk) begin
      desel_q <= (!aresetn || !chip_select_low) ? 4'h0 : desel_q + {3'h0, desel_q != 4'hf};
      ser_q <= (!aresetn || parallel_serial_strap) ? 4'h0 : ser_q + {3'h0, ser_q != 4'hf};
   end
   a_wr_block: assert property (bvalid |-> !awready && !wready)
      else $error("write channel ready while response pending");
   a_rd_block: assert property (rvalid |-> !arready)
      else $error("read address ready while data pending");
   a_b_stand: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response withdrawn early");
   a_r_stand: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
      else $error("read data withdrawn early");
   a_b_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
      else $error("write response late");
   a_r_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read data late");
   a_rd_unmapped: assert property (arvalid && arready && araddr != 4'h0 && araddr != 4'h4
      |=> rresp == 2'b11 && rdata == 32'h0)
      else $error("unmapped read not refused");
   a_wr_unmapped: assert property (awvalid && awready && wvalid && wready && awaddr != 4'h0
      && awaddr != 4'h4 |-> ##2 bresp == 2'b11)
      else $error("unmapped write not refused");
   a_oe_desel: assert property (desel_q >= 4'h8 |-> data_line_oe == 8'h00)
      else $error("data lines driven while deselected");
   a_oe_serial: assert property (ser_q >= 4'h6 |-> (data_line_oe & 8'hbf) == 8'h00)
      else $error("parallel lines driven in serial mode");
endmodule // cdh_port_sva
bind cdh_port cdh_port_sva cdh_port_sva_i (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wvalid,
   .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
   .chip_select_low, .data_line_oe, .parallel_serial_strap);
`default_nettype wire

// ### cdh_host.sv
// host processor model driving the parallel pins in either bus style
`default_nettype none
module cdh_host (
   // clock and bus style
   input wire logic aclk,
   input wire logic style,
   // pins toward the device
   output logic rs,
   output logic strb_a,
   output logic strb_b,
   output logic cs_n,
   output wire logic [7:0] lines,
   // device drive
   input wire logic [7:0] dev_out,
   input wire logic [7:0] dev_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] hd;
   // after a parallel cycle released lines show the inverse of its byte, after a serial frame 00h, never a held value
   assign lines = (dev_oe & dev_out) | (~dev_oe & hd);
   initial begin
      rs = 1'b0;
      strb_a = 1'b1;
      strb_b = 1'b1;
      cs_n = 1'b1;
      hd = 8'h00;
   end
   // idle enable level follows the style only while deselected
   always @(posedge aclk) if (cs_n) strb_a <= !style;
   // last low keeps the chip selected: the device drops a half byte on deselect
   task automatic cyc(input logic sel, input logic rd, input logic [7:0] v, input logic last,
      output logic [7:0] r);
      @(posedge aclk);
      rs <= sel;
      cs_n <= 1'b0;
      hd <= v;
      if (style) strb_b <= rd;
      @(posedge aclk);
      if (style) strb_a <= 1'b1;
      else if (rd) strb_a <= 1'b0;
      else strb_b <= 1'b0;
      repeat (6) @(posedge aclk);
      r = lines;
      if (style) strb_a <= 1'b0;
      else begin
         strb_a <= 1'b1;
         strb_b <= 1'b1;
      end
      repeat (4) @(posedge aclk);
      cs_n <= last;
      hd <= ~v;
      strb_b <= 1'b1;
   endtask
   // serial frame: clock on line 5 stays low outside frames, data on 7, answer on 6
   task automatic ser(input logic [9:0] f, output logic [7:0] r);
      for (int i = 0; i < 10; i++) begin
         @(posedge aclk);
         cs_n <= 1'b0;
         hd <= {f[9 - i], 7'h00};
         repeat (3) @(posedge aclk);
         r = {r[6:0], lines[6]};
         hd <= {f[9 - i], 2'b01, 5'h00};
         repeat (2) @(posedge aclk);
      end
      repeat (3) @(posedge aclk);
      cs_n <= 1'b1;
      hd <= 8'h00;
   endtask
endmodule // cdh_host
`default_nettype wire

// ### tb.sv
// self-checking testbench for the host port against a reference model
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ps, style;
   logic [3:0] awaddr, araddr;
   logic [31:0] wdata, d;
   wire awready, wready, bvalid, arready, rvalid, rs, sa, sb, cs_n;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [7:0] lin, dout, doe;
   int num_errors = 0, comparisons = 0, cyc_n = 0;
   int ptr = 0, gly = 0, dl = 1, dir = 1, sh = 0, ofs = 0;
   logic [7:0] tram [128], gram [64], b, m, a;
   logic [1:0] r;
   cdh_port cdh_port_i (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .register_select(rs), .enable_or_read_strobe(sa), .rw_or_write_strobe(sb), .chip_select_low(cs_n),
      .data_line_in(lin), .data_line_out(dout), .data_line_oe(doe), .parallel_serial_strap(ps),
      .bus_style_strap(style));
   cdh_host cdh_host_i (.aclk, .style, .rs, .strb_a(sa), .strb_b(sb), .cs_n, .lines(lin), .dev_out(dout),
      .dev_oe(doe));
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc_n++;
      if (cyc_n == 60000) begin
         num_errors++;
         $display("Error at %0t: run did not finish", $time);
         test_done();
      end
   end
   task automatic test_done();
      if (num_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic axi_wr(input logic [3:0] ad, input logic [31:0] v, output logic [1:0] rr);
      @(posedge aclk);
      awaddr <= ad;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      forever begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) break;
         if (bvalid) bready <= 1'b1;
      end
      rr = bresp;
      bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [3:0] ad, output logic [31:0] v, output logic [1:0] rr);
      @(posedge aclk);
      araddr <= ad;
      arvalid <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) break;
         if (rvalid) rready <= 1'b1;
      end
      v = rdata;
      rr = rresp;
      rready <= 1'b0;
   endtask
   function automatic logic [31:0] st_exp();
      return {9'h0, ofs[6:0], style, ps, gly[0], sh[0], dir[0], 1'b0, dl[0], 2'b00, ptr[6:0]};
   endfunction
   task automatic step();
      ptr = gly ? (ptr + (dir ? 1 : -1)) & 63 : ptr + (dir ? 1 : -1);
   endtask
   task automatic m_wr(input logic sel, input logic [7:0] v);
      if (sel) begin
         if (gly) gram[ptr] = v;
         else tram[ptr] = v;
         if (sh) ofs += dir ? 1 : -1;
         step();
      end else if (v[7]) begin
         ptr = v[6:0];
         gly = 0;
      end else if (v[6]) begin
         ptr = v[5:0];
         gly = 1;
      end else if (v[5]) dl = v[4];
      else if (v[2]) begin
         dir = v[1];
         sh = v[0];
      end else if (v[1]) begin
         ptr = 0;
         gly = 0;
         ofs = 0;
      end
   endtask
   task automatic xfer(input logic sel, input logic rd, input logic [7:0] v, output logic [7:0] rb);
      logic [7:0] h, l;
      if (!ps) cdh_host_i.ser({sel, rd, v}, rb);
      else if (dl) cdh_host_i.cyc(sel, rd, v, 1'b1, rb);
      else begin
         cdh_host_i.cyc(sel, rd, {v[7:4], 4'($urandom)}, 1'b0, h);
         cdh_host_i.cyc(sel, rd, {v[3:0], 4'($urandom)}, 1'b1, l);
         rb = {h[7:4], l[7:4]};
      end
   endtask
   task automatic poll();
      int n;
      n = 0;
      do begin
         xfer(1'b0, 1'b1, 8'($urandom), b);
         n++;
      end while (b[7] !== 1'b0 && n < 40);
      chk(32'(b), 32'(ptr[6:0]));
      axi_rd(4'h4, d, r);
      chk(d, st_exp());
   endtask
   task automatic pw(input logic sel, input logic [7:0] v);
      xfer(sel, 1'b0, v, m);
      m_wr(sel, v);
      poll();
   endtask
   task automatic pr();
      xfer(1'b1, 1'b1, 8'($urandom), b);
      chk(32'(b), 32'(gly ? gram[ptr] : tram[ptr]));
      step();
      poll();
   endtask
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
      ps = 1'b1;
      style = 1'b0;
      void'($urandom(63479));
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(4'h4, d, r);
      chk(d, st_exp());
      axi_rd(4'h0, d, r);
      chk(d, 32'h1);
      axi_rd(4'h8, d, r);
      chk({d[29:0], r}, 32'h3);
      axi_wr(4'hc, 32'h0, r);
      chk(32'(r), 32'h3);
      axi_wr(4'h4, 32'hffff_ffff, r);
      chk(32'(r), 32'h0);
      for (int s = 0; s < 2; s++) begin
         style <= s[0];
         repeat (4) @(posedge aclk);
         a = 8'h10 + 8'($urandom % 32);
         pw(1'b0, 8'h80 | a);
         repeat (3) pw(1'b1, 8'($urandom));
         pw(1'b0, 8'h80 | a);
         repeat (3) pr();
      end
      pw(1'b0, 8'h04);
      pw(1'b1, 8'($urandom));
      pw(1'b0, 8'h07);
      pw(1'b1, 8'($urandom));
      pw(1'b0, 8'h45);
      pw(1'b1, 8'($urandom));
      pw(1'b0, 8'h45);
      pr();
      pw(1'b0, 8'h02);
      xfer(1'b0, 1'b0, 8'h90, m);
      xfer(1'b0, 1'b0, 8'ha0, m);
      m_wr(1'b0, 8'h90);
      poll();
      pw(1'b0, 8'h20);
      pw(1'b0, 8'ha2);
      pw(1'b1, 8'($urandom));
      pw(1'b0, 8'ha2);
      pr();
      pw(1'b0, 8'h30);
      for (int k = 0; k < 2; k++) begin
         if (k == 0) ps <= 1'b0;
         else axi_wr(4'h0, 32'h0, r);
         repeat (4) @(posedge aclk);
         cdh_host_i.cyc(1'b0, 1'b0, 8'hb3, 1'b1, m);
         repeat (30) @(posedge aclk);
         axi_rd(4'h4, d, r);
         chk(d, st_exp());
         if (k == 0) begin
            pw(1'b0, 8'h80 | a);
            pw(1'b1, 8'($urandom));
            pw(1'b0, 8'h80 | a);
            pr();
         end
         ps <= 1'b1;
         axi_wr(4'h0, 32'h1, r);
      end
      repeat (4) @(posedge aclk);
      poll();
      test_done();
   end
endmodule // tb
`default_nettype wire
